// ### bench/optical_pulse_chk.sv
`timescale 1ns/100ps
`default_nettype none
module optical_pulse_chk #(
    parameter int SAMPLE_CYCLES = 20
) (
    input wire logic        clk_sys,
    input wire logic        rstn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        uart_txd,
    input wire logic        uart_rxd,
    input wire logic        rx_comparator,
    input wire logic        general_io_one_out,
    input wire logic        general_io_one_oe,
    input wire logic        general_io_one_in,
    input wire logic        general_io_two_out,
    input wire logic        general_io_two_oe,
    input wire logic        ce_pulse,
    input wire logic        optical_receive_pin_in,
    input wire logic        optical_receive_pin_out,
    input wire logic        optical_receive_pin_oe,
    input wire logic        optical_transmit_pin_out,
    input wire logic        optical_transmit_pin_oe,
    input wire logic        energy_pulse_out
);
    // ========================================================
    // shadow of the configuration
    // ========================================================
    logic        alive_r, dig_r, rinv_r, mod_r, tinv_r, pinv_r, wr;
    logic [1:0]  sel_r;
    logic [7:0]  mw_r, iv_r;
    logic [15:0] run_r;
    assign wr = psel & penable & pready & pwrite;
    // copied at the access edge, so it moves with the real registers
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            {alive_r, dig_r, rinv_r, mod_r, tinv_r, pinv_r, sel_r, iv_r} <= '0;
            mw_r <= 8'hff;
            run_r <= '0;
        end else begin
            alive_r <= 1'b1;
            if (wr && paddr == {optical_pulse_pkg::IDX_OPT_CFG, 2'h0})
                {dig_r, rinv_r, mod_r, tinv_r} <= {pwdata[5:4], pwdata[1:0]};
            if (wr && paddr == {optical_pulse_pkg::IDX_TX_CFG, 2'h0})
                sel_r <= pwdata[7:6];
            if (wr && paddr == {optical_pulse_pkg::IDX_PULSE_CFG, 2'h0})
                pinv_r <= pwdata[6];
            if (wr && paddr == {optical_pulse_pkg::IDX_MAX_WIDTH, 2'h0})
                mw_r <= pwdata[7:0];
            if (wr && paddr == {optical_pulse_pkg::IDX_INTERVAL, 2'h0})
                iv_r <= pwdata[7:0];
            // active run length, saturating so it never wraps back under the cap
            run_r <= (energy_pulse_out ^ pinv_r) ? 16'h0 : run_r + {15'h0, run_r != 16'hffff};
        end
    end
    // ========================================================
    // properties
    // ========================================================
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    a_apb_ready: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("pready not one cycle after setup");
    a_rx_uart: assert property (alive_r |-> uart_rxd == $past(dig_r | (rx_comparator ^ rinv_r)))
        else $error("uart receive level wrong");
    a_rx_dio: assert property (alive_r |-> general_io_one_in == $past(dig_r & optical_receive_pin_in)
        && optical_receive_pin_oe == $past(dig_r & general_io_one_oe)
        && optical_receive_pin_out == $past(dig_r & general_io_one_out)) else $error("receive pin io wrong");
    a_tx_uart: assert property (alive_r && $past(sel_r == 2'h0 && !mod_r) |->
        optical_transmit_pin_out == $past(uart_txd ^ tinv_r) && optical_transmit_pin_oe) else $error("tx uart wrong");
    a_tx_mod_high: assert property (alive_r && $past(sel_r == 2'h0 && (uart_txd ^ tinv_r)) |->
        optical_transmit_pin_out) else $error("tx modulated while high");
    a_tx_gpio: assert property (alive_r && $past(sel_r == 2'h1) |->
        optical_transmit_pin_out == $past(general_io_two_out) && optical_transmit_pin_oe == $past(general_io_two_oe))
        else $error("tx io path wrong");
    a_tx_reserved: assert property (alive_r && $past(sel_r == 2'h3) |-> optical_transmit_pin_out
        && optical_transmit_pin_oe) else $error("tx reserved code wrong");
    a_pulse_direct: assert property (alive_r && $past(iv_r == 8'h0 && mw_r == 8'hff) |->
        energy_pulse_out == $past(~(ce_pulse ^ pinv_r))) else $error("direct pulse wrong");
    a_width_cap: assert property (iv_r == 8'h0 && mw_r != 8'hff |->
        run_r <= 16'((2 * mw_r + 1) * SAMPLE_CYCLES + 2)) else $error("pulse exceeds width cap");
    c_mod: cover property (mod_r && sel_r == 2'h0 && !optical_transmit_pin_out);
    c_cap: cover property (mw_r != 8'hff && run_r == 16'(2 * mw_r * SAMPLE_CYCLES));
    c_queue: cover property (iv_r != 8'h0 && !energy_pulse_out);
endmodule // optical_pulse_chk
`default_nettype wire

// ### bench/optical_transceiver_model.sv
`timescale 1ns/100ps
`default_nettype none
module optical_transceiver_model (
    input  wire logic clk_sys,
    input  wire logic led_out,
    input  wire logic led_oe,
    input  wire logic pin_out,
    input  wire logic pin_oe,
    input  wire logic light,
    output logic      rx_comparator,
    output logic      pin_in,
    output logic      led_seen
);
    logic last_r = 1'b0;
    // an undriven led shows the inverse of its last level, never a stale copy
    always @(posedge clk_sys) if (led_oe) last_r <= led_out;
    assign led_seen = led_oe ? led_out : ~last_r;
    // photodetector owns the pad unless the device drives it as io
    assign pin_in = pin_oe ? pin_out : light;
    assign rx_comparator = pin_in;
endmodule // optical_transceiver_model
`default_nettype wire

// ### bench/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
    localparam int S = 20;
    localparam logic [15:0] A_OPT = {optical_pulse_pkg::IDX_OPT_CFG, 2'h0};
    localparam logic [15:0] A_TX = {optical_pulse_pkg::IDX_TX_CFG, 2'h0};
    localparam logic [15:0] A_PLS = {optical_pulse_pkg::IDX_PULSE_CFG, 2'h0};
    localparam logic [15:0] A_MW = {optical_pulse_pkg::IDX_MAX_WIDTH, 2'h0};
    localparam logic [15:0] A_IV = {optical_pulse_pkg::IDX_INTERVAL, 2'h0};
    localparam logic [15:0] A_ALL [5] = '{A_PLS, A_TX, A_OPT, A_MW, A_IV};
    localparam logic [31:0] RST [5] = '{32'h0, 32'h0, 32'h0, 32'hff, 32'h0};
    localparam logic [31:0] MSK [5] = '{32'h40, 32'hc3, 32'h33, 32'hff, 32'hff};
    logic clk_sys = 1'b0, rstn, psel, penable, pwrite, uart_txd, light, ce_pulse, rand_on, pinv, e;
    logic general_io_one_out, general_io_one_oe, general_io_two_out, general_io_two_oe;
    logic [15:0] paddr;
    logic [31:0] pwdata, q, r, seed;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, uart_rxd, rx_comparator, general_io_one_in, optical_receive_pin_in;
    wire logic optical_receive_pin_out, optical_receive_pin_oe, optical_transmit_pin_out, optical_transmit_pin_oe;
    wire logic energy_pulse_out, led_seen;
    int n_fail, n_compared, i, n;
    // short sample and pace units keep the pulse runs brief
    optical_pulse_port #(.SAMPLE_CYCLES(S), .PACE_UNIT_CYCLES(4)) uut (.*);
    optical_transceiver_model peer (.clk_sys(clk_sys), .led_out(optical_transmit_pin_out),
        .led_oe(optical_transmit_pin_oe), .pin_out(optical_receive_pin_out), .pin_oe(optical_receive_pin_oe),
        .light(light), .rx_comparator(rx_comparator), .pin_in(optical_receive_pin_in), .led_seen(led_seen));
    always #20 clk_sys = ~clk_sys;
    // random pin traffic, checked by the bound properties
    always @(posedge clk_sys) if (rand_on) {uart_txd, light, general_io_one_out, general_io_one_oe,
        general_io_two_out, general_io_two_oe, ce_pulse} <= 7'($random(seed));
    // ========================================================
    // helpers
    // ========================================================
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", nm, exp, got);
            n_fail++;
        end
    endtask
    task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        {psel, penable} <= 2'h0;
    endtask
    task pls(input int hold, input int reps, input int win);
        int k;
        n = 0;
        for (k = 0; k < reps * (hold + 3) + win; k++) begin
            @(posedge clk_sys);
            ce_pulse <= (k < reps * (hold + 3)) && (k % (hold + 3) < hold);
            @(negedge clk_sys);
            n += (energy_pulse_out === pinv);
        end
    endtask
    function automatic logic ex_tx(input logic [1:0] s, input logic inv, input logic u);
        case (s)
            2'h0: return u ^ inv;
            2'h1: return ~u;
            2'h2: return ~inv;
            default: return 1'b1;
        endcase
    endfunction
    task tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        #400000;
        n_fail++;
        tally_and_finish;
    end
    // ========================================================
    // main sequence
    // ========================================================
    initial begin
        {rstn, psel, penable, pwrite, uart_txd, light, ce_pulse, rand_on, pinv, paddr, pwdata} = '0;
        {general_io_one_out, general_io_one_oe, general_io_two_out, general_io_two_oe} = '0;
        {seed, n_fail, n_compared} = {32'hc5b8, 64'h0};
        repeat (4) @(posedge clk_sys);
        rstn <= 1'b1;
        for (i = 0; i < 5; i++) begin
            apb(1'b0, A_ALL[i], 32'h0);
            chk("reset value", RST[i], q);
            r = $random(seed) & MSK[i];
            apb(1'b1, A_ALL[i], r);
            apb(1'b0, A_ALL[i], 32'h0);
            chk("read back", r, q);
            apb(1'b1, A_ALL[i], RST[i]);
        end
        apb(1'b0, 16'h8000, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, e});
        apb(1'b0, {optical_pulse_pkg::IDX_PULSE_STAT, 2'h0}, 32'h0);
        chk("status idle", 32'h0, q);
        rand_on <= 1'b1;
        for (i = 0; i < 20; i++) begin
            r = $random(seed);
            apb(1'b1, A_OPT, r & 32'h33);
            apb(1'b1, A_TX, r & 32'hc3);
            repeat (8) @(posedge clk_sys);
        end
        rand_on <= 1'b0;
        @(posedge clk_sys);
        {ce_pulse, general_io_one_oe, general_io_two_oe} <= 3'h1;
        for (i = 0; i < 8; i++) begin
            apb(1'b1, A_OPT, {26'h0, i[1:0], 4'h0});
            light <= i[2];
            repeat (3) @(posedge clk_sys);
            @(negedge clk_sys);
            chk("uart rx", {31'h0, i[1] | (i[2] ^ i[0])}, {31'h0, uart_rxd});
            chk("dio in", {31'h0, i[1] & i[2]}, {31'h0, general_io_one_in});
        end
        for (i = 0; i < 16; i++) begin
            apb(1'b1, A_TX, {24'h0, i[1:0], 6'h0});
            apb(1'b1, A_OPT, {31'h0, i[2]});
            {uart_txd, general_io_two_out} <= {i[3], ~i[3]};
            repeat (3) @(posedge clk_sys);
            @(negedge clk_sys);
            chk("tx pin", {31'h0, ex_tx(i[1:0], i[2], i[3])}, {31'h0, led_seen});
        end
        for (i = 0; i < 16; i++) begin
            apb(1'b1, A_TX, {30'h0, i[1:0]});
            apb(1'b1, A_OPT, {30'h0, 1'b1, i[2]});
            uart_txd <= i[3];
            repeat (3) @(posedge clk_sys);
            n = 0;
            repeat (16) begin
                @(negedge clk_sys);
                n += (optical_transmit_pin_out === 1'b0);
            end
            chk("carrier lows", (i[3] ^ i[2]) ? 0 : 8 >> i[1:0], n);
        end
        for (i = 0; i < 2; i++) begin
            apb(1'b1, A_PLS, {25'h0, i[0], 6'h0});
            pinv = i[0];
            pls(50, 1, 10);
            chk("direct pulse", 50, n);
        end
        apb(1'b1, A_PLS, 32'h0);
        pinv = 1'b0;
        apb(1'b1, A_MW, 32'h2);
        pls(300, 1, 10);
        chk("capped pulse", 1, n >= 4 * S && n <= 5 * S + 2);
        apb(1'b1, A_MW, 32'hff);
        apb(1'b1, A_IV, 32'd81);
        pls(3, 2, 1700);
        chk("paced pulses", 1, n >= 646 && n <= 650);
        tally_and_finish;
    end
endmodule // tb
bind optical_pulse_port optical_pulse_chk #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) chk_i (.*);
`default_nettype wire

// ### verilog/optical_pulse_pkg.sv
`default_nettype none
// ============================================================
// shared constants for the optical port and pulse output block
// ============================================================
package optical_pulse_pkg;

    // ========================================================
    // register indices (byte address = index * 4)
    // ========================================================
    localparam logic [13:0] IDX_PULSE_CFG  = 14'h2004;
    localparam logic [13:0] IDX_TX_CFG     = 14'h2007;
    localparam logic [13:0] IDX_OPT_CFG    = 14'h2008;
    localparam logic [13:0] IDX_MAX_WIDTH  = 14'h2080;
    localparam logic [13:0] IDX_INTERVAL   = 14'h2081;
    localparam logic [13:0] IDX_PULSE_STAT = 14'h2082;

    // ========================================================
    // field positions
    // ========================================================
    localparam int POS_PULSE_INV = 6;
    localparam int POS_TX_SEL    = 6;
    localparam int POS_TX_DUTY   = 0;
    localparam int POS_RX_DIG    = 5;
    localparam int POS_RX_INV    = 4;
    localparam int POS_TX_MOD    = 1;
    localparam int POS_TX_INV    = 0;
    localparam int POS_ST_ACTIVE = 0;
    localparam int POS_ST_SPENT  = 1;
    localparam int POS_ST_PEND   = 8;

    // ========================================================
    // reset values
    // ========================================================
    localparam logic [7:0] RST_MAX_WIDTH = 8'hff;
    localparam logic [7:0] RST_INTERVAL  = 8'h00;
    localparam logic [1:0] RST_TX_SEL    = 2'h0;
    localparam logic [1:0] RST_TX_DUTY   = 2'h0;

    // ========================================================
    // codes
    // ========================================================
    localparam logic [1:0] TXSRC_UART  = 2'h0;
    localparam logic [1:0] TXSRC_GPIO  = 2'h1;
    localparam logic [1:0] TXSRC_PULSE = 2'h2;
    localparam logic [7:0] WIDTH_NO_LIMIT = 8'hff;

    // ========================================================
    // timing
    // ========================================================
    localparam int CLK_PERIOD_NS    = 40;
    localparam int SAMPLE_PERIOD_NS = 397000;
    localparam int SAMPLE_CYCLES    = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
    localparam int PACE_UNIT_CYCLES = 16;

    typedef enum logic [1:0] {PACE_IDLE, PACE_ACTIVE, PACE_GAP} pace_state_e;

endpackage : optical_pulse_pkg
`default_nettype wire

// ### verilog/optical_pulse_port.sv
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - rx pin: comparator input or digital io
// - rx invert affects only uart input
// - tx source: uart, io, pulse, reserved
// - tx invert applied before modulation
// - modulate tx only where it is zero
// - duty field picks carrier low time
// - pulse width capped at 2n+1 intervals on the direct path only
// - interval zero bypasses the pulse queue
// - pulse active low, invert makes high
module optical_pulse_port #(
    parameter int SAMPLE_CYCLES    = optical_pulse_pkg::SAMPLE_CYCLES,
    parameter int PACE_UNIT_CYCLES = optical_pulse_pkg::PACE_UNIT_CYCLES
) (
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [15:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        uart_txd,
    output logic             uart_rxd,
    input  wire logic        rx_comparator,
    input  wire logic        general_io_one_out,
    input  wire logic        general_io_one_oe,
    output logic             general_io_one_in,
    input  wire logic        general_io_two_out,
    input  wire logic        general_io_two_oe,
    input  wire logic        ce_pulse,
    input  wire logic        optical_receive_pin_in,
    output logic             optical_receive_pin_out,
    output logic             optical_receive_pin_oe,
    output logic             optical_transmit_pin_out,
    output logic             optical_transmit_pin_oe,
    output logic             energy_pulse_out
);

    // ========================================================
    // state
    // ========================================================
    typedef struct packed {
        // software fields
        logic                           pulse_inv;
        logic [1:0]                     tx_sel;
        logic [1:0]                     tx_duty;
        logic                           rx_dig;
        logic                           rx_inv;
        logic                           tx_mod;
        logic                           tx_inv;
        logic [7:0]                     max_width;
        logic [7:0]                     interval;

        // timers
        logic [15:0]                    samp_cnt;
        logic [7:0]                     unit_cnt;
        logic [7:0]                     ivl_cnt;
        logic [3:0]                     mod_phase;

        // pulse path
        logic                           ce_prev;
        logic [7:0]                     pend;

        optical_pulse_pkg::pace_state_e pstate;
        logic [8:0]                     width_cnt;
        logic                           spent;
        logic                           active;

        // bus answer
        logic                           pready;
        logic                           pslverr;
        logic [31:0]                    prdata;

        // pin levels
        logic                           uart_rxd;
        logic                           io1_in;
        logic                           rx_out;
        logic                           rx_oe;
        logic                           tx_out;
        logic                           tx_oe;
        logic                           pulse_pin;
    } state_s;

    state_s st_r;
    state_s st_nxt;

    // ========================================================
    // helpers
    // ========================================================
    // register hit test, shared by the read and write paths
    function automatic logic hit(input logic [15:0] addr, input logic [13:0] idx);
        hit = (addr[1:0] == 2'h0) && (addr[15:2] == idx);
    endfunction

    // carrier low-time: 50, 25, 12.5 or 6.25 percent of 16 phases
    function automatic logic carrier(input logic [1:0] duty, input logic [3:0] phase);
        logic [4:0] low_phases;
        low_phases = 5'h10 >> (5'h1 + {3'h0, duty});
        carrier = ({1'b0, phase} >= low_phases);
    endfunction

    // timer end counts
    localparam logic [15:0] SAMP_LAST = 16'(SAMPLE_CYCLES - 1);
    localparam logic [7:0]  UNIT_LAST = 8'(PACE_UNIT_CYCLES - 1);

    logic       acc;
    logic       wr_en;
    logic       mapped;

    logic       samp_tick;
    logic       unit_tick;
    logic       pace_tick;

    logic       ce_rise;
    logic       pend_take;
    logic [8:0] width_lim;

    logic       tx_base;
    logic       tx_inv_v;

    // ========================================================
    // next state
    // ========================================================
    always_comb begin
        st_nxt = st_r;

        // apb: answer prepared in setup, so access ends after one cycle
        acc    = psel && penable && st_r.pready;
        wr_en  = acc && pwrite;

        mapped = hit(paddr, optical_pulse_pkg::IDX_PULSE_CFG) || hit(paddr, optical_pulse_pkg::IDX_TX_CFG)
              || hit(paddr, optical_pulse_pkg::IDX_OPT_CFG) || hit(paddr, optical_pulse_pkg::IDX_MAX_WIDTH)
              || hit(paddr, optical_pulse_pkg::IDX_INTERVAL) || hit(paddr, optical_pulse_pkg::IDX_PULSE_STAT);

        st_nxt.pready  = psel && !penable;
        st_nxt.pslverr = psel && !penable && !mapped;
        st_nxt.prdata  = 32'h0;
        // read mux
        if (psel && !penable && !pwrite) begin
            if (hit(paddr, optical_pulse_pkg::IDX_PULSE_CFG))
                st_nxt.prdata[optical_pulse_pkg::POS_PULSE_INV] = st_r.pulse_inv;

            if (hit(paddr, optical_pulse_pkg::IDX_TX_CFG)) begin
                st_nxt.prdata[optical_pulse_pkg::POS_TX_SEL +: 2]  = st_r.tx_sel;
                st_nxt.prdata[optical_pulse_pkg::POS_TX_DUTY +: 2] = st_r.tx_duty;
            end

            if (hit(paddr, optical_pulse_pkg::IDX_OPT_CFG)) begin
                st_nxt.prdata[optical_pulse_pkg::POS_RX_DIG] = st_r.rx_dig;
                st_nxt.prdata[optical_pulse_pkg::POS_RX_INV] = st_r.rx_inv;
                st_nxt.prdata[optical_pulse_pkg::POS_TX_MOD] = st_r.tx_mod;
                st_nxt.prdata[optical_pulse_pkg::POS_TX_INV] = st_r.tx_inv;
            end

            if (hit(paddr, optical_pulse_pkg::IDX_MAX_WIDTH))
                st_nxt.prdata[7:0] = st_r.max_width;

            if (hit(paddr, optical_pulse_pkg::IDX_INTERVAL))
                st_nxt.prdata[7:0] = st_r.interval;

            if (hit(paddr, optical_pulse_pkg::IDX_PULSE_STAT)) begin
                st_nxt.prdata[optical_pulse_pkg::POS_ST_ACTIVE]  = st_r.active;
                st_nxt.prdata[optical_pulse_pkg::POS_ST_SPENT]   = st_r.spent;
                st_nxt.prdata[optical_pulse_pkg::POS_ST_PEND +: 8] = st_r.pend;
            end
        end

        // register writes; the status word is read-only
        if (wr_en && hit(paddr, optical_pulse_pkg::IDX_PULSE_CFG))
            st_nxt.pulse_inv = pwdata[optical_pulse_pkg::POS_PULSE_INV];

        if (wr_en && hit(paddr, optical_pulse_pkg::IDX_TX_CFG)) begin
            st_nxt.tx_sel  = pwdata[optical_pulse_pkg::POS_TX_SEL +: 2];
            st_nxt.tx_duty = pwdata[optical_pulse_pkg::POS_TX_DUTY +: 2];
        end

        if (wr_en && hit(paddr, optical_pulse_pkg::IDX_OPT_CFG)) begin
            st_nxt.rx_dig = pwdata[optical_pulse_pkg::POS_RX_DIG];
            st_nxt.rx_inv = pwdata[optical_pulse_pkg::POS_RX_INV];
            st_nxt.tx_mod = pwdata[optical_pulse_pkg::POS_TX_MOD];
            st_nxt.tx_inv = pwdata[optical_pulse_pkg::POS_TX_INV];
        end

        if (wr_en && hit(paddr, optical_pulse_pkg::IDX_MAX_WIDTH))
            st_nxt.max_width = pwdata[7:0];

        // values other than 0 and 81 are not checked; software keeps to 81
        if (wr_en && hit(paddr, optical_pulse_pkg::IDX_INTERVAL))
            st_nxt.interval = pwdata[7:0];

        // free-running sample and pacing-unit timers
        samp_tick        = (st_r.samp_cnt == SAMP_LAST);
        st_nxt.samp_cnt  = samp_tick ? 16'h0 : st_r.samp_cnt + 16'h1;

        unit_tick        = (st_r.unit_cnt == UNIT_LAST);
        st_nxt.unit_cnt  = unit_tick ? 8'h0 : st_r.unit_cnt + 8'h1;

        pace_tick        = 1'b0;
        if (st_r.interval == 8'h0) begin
            st_nxt.ivl_cnt = 8'h0;
        end else if (unit_tick) begin
            pace_tick      = (st_r.ivl_cnt >= st_r.interval - 8'h1);
            st_nxt.ivl_cnt = pace_tick ? 8'h0 : st_r.ivl_cnt + 8'h1;
        end

        // carrier phase
        st_nxt.mod_phase = st_r.mod_phase + 4'h1;

        // energy pulse shaping
        st_nxt.ce_prev = ce_pulse;
        ce_rise        = ce_pulse && !st_r.ce_prev;

        width_lim      = {st_r.max_width, 1'b1};
        pend_take      = 1'b0;

        if (st_r.interval == 8'h0) begin
            // direct path: follow the engine, cut long pulses
            st_nxt.pend   = 8'h0;
            st_nxt.pstate = optical_pulse_pkg::PACE_IDLE;
            if (!ce_pulse) begin
                st_nxt.spent     = 1'b0;
                st_nxt.width_cnt = 9'h0;
            end else if (st_r.active && samp_tick) begin
                st_nxt.width_cnt = st_r.width_cnt + 9'h1;
                if (st_r.max_width != optical_pulse_pkg::WIDTH_NO_LIMIT && st_nxt.width_cnt >= width_lim)
                    st_nxt.spent = 1'b1;
            end

            st_nxt.active = ce_pulse && !st_nxt.spent;
        end else begin
            // queued path: one interval active, one interval gap, then one interval idle before the next
            st_nxt.spent     = 1'b0;
            st_nxt.width_cnt = 9'h0;

            unique case (st_r.pstate)
                optical_pulse_pkg::PACE_IDLE: begin
                    if (pace_tick && st_r.pend != 8'h0) begin
                        pend_take     = 1'b1;
                        st_nxt.pstate = optical_pulse_pkg::PACE_ACTIVE;
                    end
                end
                optical_pulse_pkg::PACE_ACTIVE: begin
                    if (pace_tick)
                        st_nxt.pstate = optical_pulse_pkg::PACE_GAP;
                end
                optical_pulse_pkg::PACE_GAP: begin
                    if (pace_tick)
                        st_nxt.pstate = optical_pulse_pkg::PACE_IDLE;
                end
                default: st_nxt.pstate = optical_pulse_pkg::PACE_IDLE;
            endcase

            // a new pulse and a departing one in the same cycle cancel out
            if (ce_rise && !pend_take && st_r.pend != 8'hff)
                st_nxt.pend = st_r.pend + 8'h1;
            else if (pend_take && !ce_rise)
                st_nxt.pend = st_r.pend - 8'h1;
            st_nxt.active = (st_nxt.pstate == optical_pulse_pkg::PACE_ACTIVE);
        end

        st_nxt.pulse_pin = !(st_nxt.active ^ st_r.pulse_inv);

        // receive pin: analog comparator path or digital io
        if (st_r.rx_dig) begin
            st_nxt.uart_rxd = 1'b1;
            st_nxt.io1_in   = optical_receive_pin_in;
            st_nxt.rx_out   = general_io_one_out;
            st_nxt.rx_oe    = general_io_one_oe;
        end else begin
            // comparator path
            st_nxt.uart_rxd = rx_comparator ^ st_r.rx_inv;
            st_nxt.io1_in   = 1'b0;
            st_nxt.rx_out   = 1'b0;
            st_nxt.rx_oe    = 1'b0;
        end

        // transmit pin: source, then invert, then modulate
        tx_base  = (st_r.tx_sel == optical_pulse_pkg::TXSRC_PULSE) ? st_r.pulse_pin : uart_txd;

        tx_inv_v = tx_base ^ st_r.tx_inv;

        if (st_r.tx_sel == optical_pulse_pkg::TXSRC_GPIO) begin
            st_nxt.tx_out = general_io_two_out;
            st_nxt.tx_oe  = general_io_two_oe;
        end else if (st_r.tx_sel == 2'h3) begin
            // reserved code: park the pin at the idle level
            st_nxt.tx_out = 1'b1;
            st_nxt.tx_oe  = 1'b1;
        end else begin
            st_nxt.tx_out = (st_r.tx_mod && !tx_inv_v) ? carrier(st_r.tx_duty, st_r.mod_phase) : tx_inv_v;
            st_nxt.tx_oe  = 1'b1;
        end
    end

    // ========================================================
    // registers
    // ========================================================
    // all state in one flop group, reset to constants only
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            st_r           <= '0;
            // named reset values and idle-high pin levels
            st_r.tx_sel    <= optical_pulse_pkg::RST_TX_SEL;
            st_r.tx_duty   <= optical_pulse_pkg::RST_TX_DUTY;
            st_r.max_width <= optical_pulse_pkg::RST_MAX_WIDTH;
            st_r.interval  <= optical_pulse_pkg::RST_INTERVAL;
            st_r.pstate    <= optical_pulse_pkg::PACE_IDLE;
            st_r.pulse_pin <= 1'b1;
            st_r.uart_rxd  <= 1'b1;
            st_r.tx_out    <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ========================================================
    // outputs, each straight from a flop
    // ========================================================
    assign prdata                   = st_r.prdata;
    assign pready                   = st_r.pready;
    assign pslverr                  = st_r.pslverr;

    assign uart_rxd                 = st_r.uart_rxd;
    assign general_io_one_in        = st_r.io1_in;

    assign optical_receive_pin_out  = st_r.rx_out;
    assign optical_receive_pin_oe   = st_r.rx_oe;

    assign optical_transmit_pin_out = st_r.tx_out;
    assign optical_transmit_pin_oe  = st_r.tx_oe;

    assign energy_pulse_out         = st_r.pulse_pin;

endmodule // optical_pulse_port
`default_nettype wire
